// >>> rtl/raster_pkg.sv
/*
 * Shared constants and carrier types of the 640x480 raster timing block.
 * Assumes a 200 MHz system clock with the 25 MHz pixel rate made from it
 * by an enable divider.
 */
package raster_pkg;

   // clock rates and the pixel enable divider
   localparam int CLK_FREQ_MHZ   = 32'h0000_00C8;
   localparam int PIXEL_FREQ_MHZ = 32'h0000_0019;
   localparam int PIX_DIV        = CLK_FREQ_MHZ / PIXEL_FREQ_MHZ;
   localparam logic [2:0] DIV_LAST = 3'(PIX_DIV - 1);

   // horizontal timing in pixel clocks
   localparam logic [9:0] H_VISIBLE = 10'h280;
   localparam logic [9:0] H_FRONT   = 10'h010;
   localparam logic [9:0] H_SYNC    = 10'h060;
   localparam logic [9:0] H_BACK    = 10'h030;
   localparam logic [9:0] H_TOTAL   = H_VISIBLE + H_FRONT + H_SYNC + H_BACK;
   localparam logic [9:0] H_LAST    = H_TOTAL - 10'h001;
   localparam logic [9:0] HS_START  = H_VISIBLE + H_FRONT;
   localparam logic [9:0] HS_END    = HS_START + H_SYNC;

   // vertical timing in lines
   localparam logic [9:0] V_VISIBLE = 10'h1E0;
   localparam logic [9:0] V_FRONT   = 10'h00A;
   localparam logic [9:0] V_SYNC    = 10'h002;
   localparam logic [9:0] V_BACK    = 10'h01D;
   localparam logic [9:0] V_TOTAL   = V_VISIBLE + V_FRONT + V_SYNC + V_BACK;
   localparam logic [9:0] V_LAST    = V_TOTAL - 10'h001;
   localparam logic [9:0] VS_START  = V_VISIBLE + V_FRONT;
   localparam logic [9:0] VS_END    = VS_START + V_SYNC;

   // pixel FIFO shape
   localparam int FIFO_DEPTH = 32'h0000_0010;

   typedef struct packed {
      logic red;
      logic green;
      logic blue;
   } colour_type;

   localparam colour_type BLACK = 3'h0;
   localparam int COLOUR_BITS   = $bits(colour_type);

   typedef struct packed {
      logic [9:0] row;
      logic [9:0] col;
   } addr_type;

   typedef enum logic [1:0] {
      ST_HOLD = 2'h1,
      ST_RUN  = 2'h2
   } state_type;

   typedef struct packed {
      state_type  st;
      logic [2:0] div;
      logic       pix_en;
      logic [9:0] h;
      logic [9:0] v;
      colour_type colour;
      logic       line_sync_n;
      logic       frame_sync_n;
      addr_type   addr;
      logic       frame_start;
      logic       underrun;
   } timing_state_type;

endpackage : raster_pkg

// >>> rtl/pixel_fifo.sv
/*
 * Synchronous FIFO of flip-flops for pixel colour words.
 * Assumes one clock domain; push and pop may happen in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
   parameter int WIDTH = 3,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // filling side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             in_ready,
   // draining side
   output var  logic             out_valid,
   output var  logic [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               rd;
      logic [AW-1:0]               wr;
      logic [AW:0]                 count;
      logic                        room;
   } fifo_state_type;

   fifo_state_type s_q;
   fifo_state_type s_d;
   logic           push;
   logic           pop;

   always_comb begin
      s_d  = s_q;
      push = in_valid && s_q.room;
      pop  = out_ready && (s_q.count != '0);
      if (push) begin
         s_d.mem[s_q.wr] = in_data;
         s_d.wr          = s_q.wr + 1'b1;
      end
      if (pop) begin
         s_d.rd = s_q.rd + 1'b1;
      end
      if (push && !pop) begin
         s_d.count = s_q.count + 1'b1;
      end else if (pop && !push) begin
         s_d.count = s_q.count - 1'b1;
      end
      s_d.room = (s_d.count != (AW+1)'(DEPTH));
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q      <= '0;
         s_q.room <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign in_ready  = s_q.room;
   assign out_valid = (s_q.count != '0);
   assign out_data  = s_q.mem[s_q.rd];

   no_overflow_a: assert property (@(posedge clk) disable iff (!rstn)
      !s_q.room |=> s_q.count == (AW+1)'(DEPTH) || $past(pop))
      else $error("fifo count moved past depth");
   fill_count_a: assert property (@(posedge clk) disable iff (!rstn)
      (push && !pop) |=> s_q.count == $past(s_q.count) + 1'b1)
      else $error("fifo count missed a push");

endmodule : pixel_fifo
`default_nettype wire

// >>> rtl/raster_timing.sv
/*
 * 640x480 raster timing generator with a pixel FIFO in the colour path.
 * Assumes a 200 MHz clk; the 25 MHz pixel rate is an enable pulse from a
 * divider. Colour words arrive in raster order from a display buffer
 * reader on the same clock; fetch_addr shows the pixel now on screen.
 */
`timescale 1ns/1ps
`default_nettype none
module raster_timing (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rstn,
   // colour stream from the display buffer
   input  wire logic                   pixel_valid,
   input  wire raster_pkg::colour_type pixel_data,
   output var  logic                   pixel_ready,
   // monitor pins
   output var  raster_pkg::colour_type colour,
   output var  logic                   line_sync_pulse_n,
   output var  logic                   frame_sync_pulse_n,
   // raster position and status
   output var  raster_pkg::addr_type   fetch_addr,
   output var  logic                   frame_start,
   output var  logic                   underrun
);

   raster_pkg::timing_state_type s_q;
   raster_pkg::timing_state_type s_d;

   logic                   fifo_out_valid;
   raster_pkg::colour_type fifo_out_data;
   logic                   fifo_pop;
   logic                   fifo_in_ready;
   logic                   visible;
   logic                   in_line_sync;
   logic                   in_frame_sync;
   logic                   line_wrap;
   logic                   frame_step;

   // colour words wait here; the reader stalls on a full FIFO
   pixel_fifo #(
      .WIDTH (raster_pkg::COLOUR_BITS),
      .DEPTH (raster_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (pixel_valid),
      .in_data   (pixel_data),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (fifo_pop)
   );

   // window decode of the current counter position
   always_comb begin
      visible       = (s_q.h < raster_pkg::H_VISIBLE)
                   && (s_q.v < raster_pkg::V_VISIBLE);
      in_line_sync  = (s_q.h >= raster_pkg::HS_START)
                   && (s_q.h < raster_pkg::HS_END);
      in_frame_sync = (s_q.v >= raster_pkg::VS_START)
                   && (s_q.v < raster_pkg::VS_END);
      line_wrap     = (s_q.h == raster_pkg::H_LAST);
      // vertical step on the onset of each line sync pulse
      frame_step    = (s_q.h == raster_pkg::HS_START);
   end

   // one pop per visible pixel, only while the pixel enable fires
   assign fifo_pop = (s_q.st == raster_pkg::ST_RUN) && s_q.pix_en
                  && visible;

   always_comb begin
      s_d             = s_q;
      s_d.frame_start = 1'b0;
      // pixel enable: one clk in PIX_DIV
      if (s_q.div == raster_pkg::DIV_LAST) begin
         s_d.div    = 3'h0;
         s_d.pix_en = 1'b1;
      end else begin
         s_d.div    = s_q.div + 3'h1;
         s_d.pix_en = 1'b0;
      end
      case (s_q.st)
         raster_pkg::ST_HOLD: begin
            // outputs stay inactive until the counters start
            s_d.colour       = raster_pkg::BLACK;
            s_d.line_sync_n  = 1'b1;
            s_d.frame_sync_n = 1'b1;
            s_d.h            = 10'h000;
            s_d.v            = 10'h000;
            if (s_q.pix_en) begin
               s_d.st = raster_pkg::ST_RUN;
            end
         end
         raster_pkg::ST_RUN: begin
            if (s_q.pix_en) begin
               // outputs show the position the counters hold now
               s_d.line_sync_n  = !in_line_sync;
               s_d.frame_sync_n = !in_frame_sync;
               s_d.addr.col     = s_q.h;
               s_d.addr.row     = s_q.v;
               s_d.frame_start  = (s_q.h == 10'h000)
                               && (s_q.v == 10'h000);
               if (visible && fifo_out_valid) begin
                  s_d.colour = fifo_out_data;
               end else begin
                  s_d.colour = raster_pkg::BLACK;
               end
               // starved in the window: show black, flag until reset
               if (visible && !fifo_out_valid) begin
                  s_d.underrun = 1'b1;
               end
               if (line_wrap) begin
                  s_d.h = 10'h000;
               end else begin
                  s_d.h = s_q.h + 10'h001;
               end
               if (frame_step) begin
                  if (s_q.v == raster_pkg::V_LAST) begin
                     s_d.v = 10'h000;
                  end else begin
                     s_d.v = s_q.v + 10'h001;
                  end
               end
            end
         end
         default: begin
            s_d.st = raster_pkg::ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q              <= '0;
         s_q.st           <= raster_pkg::ST_HOLD;
         s_q.line_sync_n  <= 1'b1;
         s_q.frame_sync_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ready register lives in the FIFO
   assign pixel_ready        = fifo_in_ready;
   assign colour             = s_q.colour;
   assign line_sync_pulse_n  = s_q.line_sync_n;
   assign frame_sync_pulse_n = s_q.frame_sync_n;
   assign fetch_addr         = s_q.addr;
   assign frame_start        = s_q.frame_start;
   assign underrun           = s_q.underrun;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   enable_spacing_a: assert property (
      s_q.pix_en |=> !s_q.pix_en [*7] ##1 s_q.pix_en)
      else $error("pixel enable not every eighth clock");

   h_step_a: assert property (
      (s_q.st == raster_pkg::ST_RUN && s_q.pix_en && s_q.h != 10'h31F)
      |=> s_q.h == $past(s_q.h) + 10'h001)
      else $error("horizontal counter did not step");

   h_wrap_a: assert property (
      (s_q.pix_en && s_q.h == 10'h31F) |=> s_q.h == 10'h000)
      else $error("horizontal counter did not wrap at 800");

   h_hold_a: assert property (
      !s_q.pix_en |=> $stable(s_q.h) && $stable(colour))
      else $error("pixel state moved without the enable");

   line_sync_a: assert property (
      (s_q.st == raster_pkg::ST_RUN && s_q.pix_en) |=>
      line_sync_pulse_n == !($past(s_q.h) >= 10'h290
                          && $past(s_q.h) < 10'h2F0))
      else $error("line sync outside 656 to 751");

   frame_sync_a: assert property (
      (s_q.st == raster_pkg::ST_RUN && s_q.pix_en) |=>
      frame_sync_pulse_n == !($past(s_q.v) >= 10'h1EA
                           && $past(s_q.v) < 10'h1EC))
      else $error("frame sync outside lines 490 and 491");

   v_step_a: assert property (
      (s_q.st == raster_pkg::ST_RUN && s_q.pix_en && s_q.h == 10'h290)
      |=> s_q.v == (($past(s_q.v) == 10'h208) ? 10'h000
                                              : $past(s_q.v) + 10'h001))
      else $error("vertical counter wrong at line sync onset");

   v_hold_a: assert property (
      !(s_q.pix_en && s_q.h == 10'h290) |=> $stable(s_q.v))
      else $error("vertical counter moved between line syncs");

   blank_colour_a: assert property (
      (s_q.pix_en && !visible) |=> colour == raster_pkg::BLACK)
      else $error("colour driven during blanking");

   hold_idle_a: assert property (
      (s_q.st == raster_pkg::ST_HOLD) |-> line_sync_pulse_n
      && frame_sync_pulse_n && colour == raster_pkg::BLACK
      && s_q.h == 10'h000 && s_q.v == 10'h000)
      else $error("outputs active before counting starts");

   pop_colour_a: assert property (
      (fifo_pop && fifo_out_valid) |=> colour == $past(fifo_out_data))
      else $error("popped colour not shown on the next pixel");

   addr_follow_a: assert property (
      (s_q.st == raster_pkg::ST_RUN && s_q.pix_en) |=>
      fetch_addr.col == $past(s_q.h) && fetch_addr.row == $past(s_q.v))
      else $error("fetch address not the position just shown");

   addr_hold_a: assert property (
      !s_q.pix_en |=> $stable(fetch_addr) && $stable(line_sync_pulse_n)
      && $stable(frame_sync_pulse_n))
      else $error("raster outputs moved without the enable");

   frame_mark_a: assert property (
      (s_q.st == raster_pkg::ST_RUN && s_q.pix_en && s_q.h == 10'h000
       && s_q.v == 10'h000) |=> frame_start)
      else $error("frame start missing at the origin");

   frame_origin_a: assert property (
      frame_start |-> fetch_addr.col == 10'h000 && fetch_addr.row == 10'h000)
      else $error("frame start away from the origin");

   frame_pulse_a: assert property (
      frame_start |=> !frame_start)
      else $error("frame start longer than one clock");

   underrun_set_a: assert property (
      (fifo_pop && !fifo_out_valid) |=>
      underrun && colour == raster_pkg::BLACK)
      else $error("starved pixel not black or not flagged");

   underrun_sticky_a: assert property (
      underrun |=> underrun)
      else $error("underrun flag dropped without reset");

   h_range_a: assert property (
      s_q.h <= 10'h31F)
      else $error("horizontal counter beyond 799");

   v_range_a: assert property (
      s_q.v <= 10'h208)
      else $error("vertical counter beyond 520");

   enable_rate_a: assert property (
      s_q.div == 3'h7 |=> s_q.pix_en)
      else $error("pixel enable missing after divider end");

   hold_leave_a: assert property (
      (s_q.st == raster_pkg::ST_HOLD && s_q.pix_en)
      |=> s_q.st == raster_pkg::ST_RUN)
      else $error("counting did not start after one pixel");

   state_onehot_a: assert property (
      $onehot(s_q.st))
      else $error("timing state not one-hot");

   line_fall_a: assert property (
      $fell(line_sync_pulse_n) |-> fetch_addr.col == 10'h290)
      else $error("line sync began away from pixel 656");

   line_rise_a: assert property (
      $rose(line_sync_pulse_n) |-> fetch_addr.col == 10'h2F0)
      else $error("line sync ended away from pixel 752");

   frame_fall_a: assert property (
      $fell(frame_sync_pulse_n) |-> fetch_addr.row == 10'h1EA)
      else $error("frame sync began away from line 490");

   frame_rise_a: assert property (
      $rose(frame_sync_pulse_n) |-> fetch_addr.row == 10'h1EC)
      else $error("frame sync ended away from line 492");

endmodule : raster_timing
`default_nettype wire

// >>> bench/vga_monitor_model.sv
/*
 * Behavioural model of the display on the far end of the cable.
 * Assumes sync outputs that change only after the rising edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none
module vga_monitor_model (
   // clock
   input  wire logic clk,
   // cable
   input  wire logic line_sync_pulse_n,
   // measured line timing in clk cycles
   output var  int   sync_width,
   output var  int   line_period
);
   int   low_cnt;
   int   since_fall;
   logic last_n;

   // line sync is active low; sampled settled, on the falling edge
   always @(negedge clk) begin
      if (last_n === 1'b1 && line_sync_pulse_n === 1'b0) begin
         line_period = since_fall;
         since_fall  = 0;
         low_cnt     = 0;
      end
      if (line_sync_pulse_n === 1'b0) low_cnt++;
      if (last_n === 1'b0 && line_sync_pulse_n === 1'b1) sync_width = low_cnt;
      since_fall++;
      last_n = line_sync_pulse_n;
   end
endmodule : vga_monitor_model
`default_nettype wire

// >>> bench/test_vga_640x480_timing_generator.sv
/*
 * Self-checking bench of the raster timing block with a monitor model.
 * Assumes the 200 MHz clk and the pixel enable every 8 clk of the design.
 */
`timescale 1ns/1ps
`default_nettype none
module test_vga_640x480_timing_generator;
   logic                   clk;
   logic                   rstn;
   logic                   pixel_valid;
   raster_pkg::colour_type pixel_data;
   logic                   pixel_ready;
   raster_pkg::colour_type colour;
   logic                   line_sync_pulse_n;
   logic                   frame_sync_pulse_n;
   raster_pkg::addr_type   fetch_addr;
   logic                   frame_start;
   logic                   underrun;
   int                     sync_width;
   int                     line_period;
   int                     n_fail;
   int                     tests_run;
   int                     n_taken;
   int                     widx;
   logic                   took;
   logic                   feed_on;

   raster_timing i_raster_timing (
      .clk(clk), .rstn(rstn), .pixel_valid(pixel_valid),
      .pixel_data(pixel_data), .pixel_ready(pixel_ready), .colour(colour),
      .line_sync_pulse_n(line_sync_pulse_n),
      .frame_sync_pulse_n(frame_sync_pulse_n), .fetch_addr(fetch_addr),
      .frame_start(frame_start), .underrun(underrun));

   vga_monitor_model i_vga_monitor_model (
      .clk(clk), .line_sync_pulse_n(line_sync_pulse_n),
      .sync_width(sync_width), .line_period(line_period));

   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   // word index as colour; a word is held until ready was seen high
   always @(negedge clk) begin
      if (took) begin
         widx    = widx + 1;
         n_taken = n_taken + 1;
      end
      pixel_valid = feed_on;
      pixel_data  = raster_pkg::colour_type'(widx[2:0]);
      took        = feed_on && (pixel_ready === 1'b1);
   end

   task automatic check_vec(string what, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check_vec

   task automatic check_bit(string what, logic exp, logic got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop

   task automatic t_reset;
      rstn = 1'b0;
      repeat (3) @(negedge clk);
      check_vec("colour", 32'h0000_0000, 32'(colour));
      check_bit("line sync", 1'b1, line_sync_pulse_n);
      check_bit("frame sync", 1'b1, frame_sync_pulse_n);
      check_vec("fetch_addr", 32'h0000_0000, 32'(fetch_addr));
      check_bit("frame_start", 1'b0, frame_start);
      check_bit("underrun", 1'b0, underrun);
      check_bit("pixel_ready", 1'b1, pixel_ready);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      check_bit("line sync", 1'b1, line_sync_pulse_n);
      check_vec("colour", 32'h0000_0000, 32'(colour));
      check_bit("frame_start", 1'b0, frame_start);
      $display("test reset done");
   endtask : t_reset

   task automatic t_first;
      int i;
      i = 0;
      while (frame_start !== 1'b1 && i < 40) begin
         @(negedge clk);
         i++;
      end
      check_bit("frame_start", 1'b1, frame_start);
      check_vec("fetch_addr", 32'h0000_0000, 32'(fetch_addr));
      check_vec("colour", 32'h0000_0000, 32'(colour));
      @(negedge clk);
      check_bit("frame_start", 1'b0, frame_start);
      repeat (8) @(negedge clk);
      check_bit("underrun", 1'b1, underrun);
      $display("test first pixel done");
   endtask : t_first

   task automatic t_fill;
      int i;
      i = 0;
      while (fetch_addr.col !== raster_pkg::H_VISIBLE && i < 7000) begin
         @(negedge clk);
         i++;
      end
      check_bit("underrun", 1'b1, underrun);
      feed_on = 1'b1;
      i = 0;
      while (pixel_ready !== 1'b0 && i < 40) begin
         @(negedge clk);
         i++;
      end
      // let the feeder book the last accepted word
      @(negedge clk);
      check_vec("words taken", 32'(raster_pkg::FIFO_DEPTH),
         32'(n_taken));
      repeat (6) @(negedge clk);
      check_vec("words refused", 32'(raster_pkg::FIFO_DEPTH),
         32'(n_taken));
      $display("test fill done");
   endtask : t_fill

   task automatic t_line;
      raster_pkg::addr_type prev;
      raster_pkg::addr_type cur;
      logic [9:0]           c;
      int                   i;
      int                   cnt;
      i = 0;
      while (fetch_addr !== 20'h0_0400 && i < 2000) begin
         @(negedge clk);
         i++;
      end
      prev = fetch_addr;
      cnt  = 0;
      for (i = 0; i < 6400; i++) begin
         @(negedge clk);
         cnt++;
         cur = fetch_addr;
         c   = cur.col;
         if (cur !== prev) begin
            check_vec("pixel period", 32'h0000_0008, 32'(cnt));
            check_vec("col step",
               32'((prev.col == raster_pkg::H_LAST) ? 10'h000 : prev.col + 10'h001),
               32'(c));
            cnt  = 0;
            prev = cur;
         end
         check_vec("colour",
            32'((cur.row < raster_pkg::V_VISIBLE && c < raster_pkg::H_VISIBLE)
                ? c[2:0] : 3'h0), 32'(colour));
         check_bit("line sync",
            !(c >= raster_pkg::HS_START && c < raster_pkg::HS_END),
            line_sync_pulse_n);
         check_bit("frame sync", 1'b1, frame_sync_pulse_n);
      end
      check_vec("sync width", 32'h0000_0300, 32'(sync_width));
      check_vec("line period", 32'h0000_1900, 32'(line_period));
      $display("test line done");
   endtask : t_line

   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      $display("watchdog expired");
      report_and_stop();
   end

   initial begin
      rstn      = 1'b0;
      feed_on   = 1'b0;
      n_fail    = 0;
      tests_run = 0;
      t_reset();
      t_first();
      t_fill();
      t_line();
      feed_on = 1'b0;
      t_reset();
      t_first();
      report_and_stop();
   end
endmodule : test_vga_640x480_timing_generator
`default_nettype wire
